// >>> rtl/logic_exec.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
// How it works
// RL1: test-and-set: T set when byte zero, five states
// RL2: test-and-set writes byte back with bit7 set
// RL3: bus stays locked from read through write
// RL4: dirty hit: write back, then invalidate
// RL5: clean hit invalidates; miss or uncached skips
// RL6: test-and-set access checked as byte store
// RL7: trap: seven states, saves pc+2, status, r15
// RL8: trap immediate shifted left two into code
// RL9: trap sets privileged, mask and bank flags
// RL10: trap writes event code into low twelve bits
// RL11: trap resumes at vector base plus offset
// RL12: register and-test sets T, one state
// RL13: immediate and-test against r0, one state
// RL14: memory and-test, no writes, three states
// RL15: xor register/immediate forms, T untouched
// RL16: memory xor writes result back, four states
// RL17: extract middle 32 bits of rm:rn
// RL18: non-trap operations advance pc by two
module logic_exec (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	output logic instr_ready,
	output logic mem_req,
	output logic mem_we,
	output logic mem_lock,
	output logic mem_store_chk,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic mem_fault,
	input wire logic [7:0] mem_rdata,
	output logic cache_req,
	output exec_pkg::cache_op_t cache_op,
	input wire logic cache_ack,
	input wire logic cache_hit,
	input wire logic cache_dirty,
	input wire logic cache_ncache
);
	// ****************************************
	// state and storage
	// ****************************************
	exec_pkg::st_t state_q;
	exec_pkg::op_t op_d, op_q;
	logic [15:0] ins_q;
	logic [2:0] cnt_q;
	logic [7:0] rbyte_q;
	logic [31:0] regs_q [16];
	logic [31:0] pc_q, vbr_q, gbr_q, sr_q;
	logic [31:0] tra_q, spc_q, ssr_q, sgr_q;
	logic [11:0] evt_q;
	logic [3:0] ridx_q;
	logic run_q;
	logic [exec_pkg::EV_W-1:0] istat_q, imask_q, ev_set;
	logic [31:0] rdata_d;
	logic taken, commit, fault, bad_op, trap_c;
	logic apb_wr, apb_rd;
	logic [2:0] need;
	logic [3:0] rn, rm;
	logic [7:0] imm;
	logic [31:0] vn, vm, v0, alu;
	logic t_new;

	op_decode op_decode_inst (
		.instr(instr),
		.op(op_d)
	);

	assign rn = ins_q[11:8];
	assign rm = ins_q[7:4];
	assign imm = ins_q[7:0];
	assign vn = regs_q[rn];
	assign vm = regs_q[rm];
	assign v0 = regs_q[0];
	assign taken = instr_valid && instr_ready;
	assign fault = mem_req && mem_ack && mem_fault;
	assign bad_op = taken && op_d == exec_pkg::OP_NONE;
	assign apb_wr = psel && penable && pwrite && pready;
	assign apb_rd = psel && !penable;

	// least state count per operation
	always_comb begin
		unique case (op_q)
			exec_pkg::OP_TEST_SET: need = exec_pkg::N_TAS; // [RL1]
			exec_pkg::OP_SOFT_TRAP: need = exec_pkg::N_TRAP; // [RL7]
			exec_pkg::OP_AND_MEM: need = exec_pkg::N_TSTB; // [RL14]
			exec_pkg::OP_XOR_MEM: need = exec_pkg::N_XORB; // [RL16]
			default: need = exec_pkg::N_ONE; // [RL12] [RL13] [RL15] [RL17]
		endcase
	end

	assign commit = state_q == exec_pkg::ST_FINISH && cnt_q >= need - 3'h1;
	assign trap_c = commit && op_q == exec_pkg::OP_SOFT_TRAP;

	// ****************************************
	// result and flag computation
	// ****************************************
	always_comb begin
		alu = vn;
		t_new = sr_q[exec_pkg::SR_T];
		unique case (op_q)
			exec_pkg::OP_TEST_SET: t_new = rbyte_q == 8'h00; // [RL1]
			exec_pkg::OP_AND_RR: t_new = (vn & vm) == 32'h0000_0000; // [RL12]
			exec_pkg::OP_AND_IMM: t_new = (v0 & {24'h00_0000, imm}) == 32'h0000_0000; // [RL13]
			exec_pkg::OP_AND_MEM: t_new = (rbyte_q & imm) == 8'h00; // [RL14]
			exec_pkg::OP_XOR_RR: alu = vn ^ vm; // [RL15]
			exec_pkg::OP_XOR_IMM: alu = v0 ^ {24'h00_0000, imm}; // [RL15]
			exec_pkg::OP_MID_EXTRACT: alu = {vm[15:0], vn[31:16]}; // [RL17]
			default: alu = vn;
		endcase
	end

	// ****************************************
	// sequencer
	// ****************************************
	// memory ops start at the cache purge or the read; others go to finish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= exec_pkg::ST_IDLE;
			op_q <= exec_pkg::OP_NONE;
			ins_q <= 16'h0000;
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
			unique case (state_q)
				exec_pkg::ST_IDLE: begin
					cnt_q <= 3'h0;
					if (taken && !bad_op) begin
						op_q <= op_d;
						ins_q <= instr;
						if (op_d == exec_pkg::OP_TEST_SET) begin
							state_q <= exec_pkg::ST_LOOK; // [RL4]
						end else if (op_d == exec_pkg::OP_AND_MEM ||
							op_d == exec_pkg::OP_XOR_MEM) begin
							state_q <= exec_pkg::ST_READ;
						end else begin
							state_q <= exec_pkg::ST_FINISH;
						end
					end
				end
				exec_pkg::ST_LOOK: begin
					if (cache_ack) begin
						if (!cache_hit || cache_ncache) begin
							state_q <= exec_pkg::ST_READ; // [RL5]
						end else if (cache_dirty) begin
							state_q <= exec_pkg::ST_WBACK; // [RL4]
						end else begin
							state_q <= exec_pkg::ST_INVAL; // [RL5]
						end
					end
				end
				exec_pkg::ST_WBACK: begin
					if (cache_ack) begin
						state_q <= exec_pkg::ST_INVAL; // [RL4]
					end
				end
				exec_pkg::ST_INVAL: begin
					if (cache_ack) begin
						state_q <= exec_pkg::ST_READ;
					end
				end
				exec_pkg::ST_READ: begin
					if (fault) begin
						state_q <= exec_pkg::ST_IDLE; // [RL6]
					end else if (mem_ack) begin
						state_q <= (op_q == exec_pkg::OP_AND_MEM) ?
							exec_pkg::ST_FINISH : exec_pkg::ST_WRITE; // [RL14]
					end
				end
				exec_pkg::ST_WRITE: begin
					if (fault) begin
						state_q <= exec_pkg::ST_IDLE;
					end else if (mem_ack) begin
						state_q <= exec_pkg::ST_FINISH;
					end
				end
				exec_pkg::ST_FINISH: begin
					if (commit) begin
						state_q <= exec_pkg::ST_IDLE;
					end
				end
				default: state_q <= exec_pkg::ST_IDLE;
			endcase
		end
	end

	// fetch handshake: accept only when idle and enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ready <= 1'b0;
		end else begin
			instr_ready <= run_q && state_q == exec_pkg::ST_IDLE && !taken;
		end
	end

	// ****************************************
	// cache purge port
	// ****************************************
	// address shared with mem_addr, loaded at take
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cache_req <= 1'b0;
			cache_op <= exec_pkg::COP_NONE;
		end else if (taken && op_d == exec_pkg::OP_TEST_SET) begin
			cache_req <= 1'b1;
			cache_op <= exec_pkg::COP_LOOKUP; // [RL4]
		end else if (cache_req && cache_ack) begin
			cache_req <= state_q == exec_pkg::ST_WBACK ||
				(state_q == exec_pkg::ST_LOOK && cache_hit && !cache_ncache);
			cache_op <= exec_pkg::COP_NONE;
			if (state_q == exec_pkg::ST_WBACK) begin
				cache_op <= exec_pkg::COP_INVAL; // [RL4]
			end else if (state_q == exec_pkg::ST_LOOK && cache_hit &&
				!cache_ncache) begin
				cache_op <= cache_dirty ? exec_pkg::COP_WBACK : exec_pkg::COP_INVAL; // [RL5]
			end
		end
	end

	// ****************************************
	// memory port
	// ****************************************
	// for test-and-set the lock spans read and write so no foreign access slips in between
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_lock <= 1'b0;
			mem_store_chk <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 8'h00;
			rbyte_q <= 8'h00;
		end else begin
			if (taken) begin
				mem_addr <= (op_d == exec_pkg::OP_TEST_SET) ?
					regs_q[instr[11:8]] : gbr_q + regs_q[0]; // [RL14] [RL16]
			end
			if (!mem_req && ((state_q == exec_pkg::ST_LOOK && cache_ack &&
				(!cache_hit || cache_ncache)) ||
				(state_q == exec_pkg::ST_INVAL && cache_ack) ||
				(taken && (op_d == exec_pkg::OP_AND_MEM ||
				op_d == exec_pkg::OP_XOR_MEM)))) begin
				mem_req <= 1'b1;
				mem_we <= 1'b0;
				mem_lock <= state_q != exec_pkg::ST_IDLE; // [RL3]
				mem_store_chk <= state_q != exec_pkg::ST_IDLE; // [RL6]
			end else if (mem_req && mem_ack) begin
				rbyte_q <= mem_we ? rbyte_q : mem_rdata;
				if (!mem_we && !fault && op_q != exec_pkg::OP_AND_MEM) begin
					mem_we <= 1'b1;
					mem_wdata <= (op_q == exec_pkg::OP_TEST_SET) ?
						(mem_rdata | exec_pkg::MSB_SET) : // [RL2]
						(mem_rdata ^ imm); // [RL16]
				end else begin
					mem_req <= 1'b0;
					mem_we <= 1'b0;
					mem_lock <= 1'b0; // [RL3]
					mem_store_chk <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// architectural registers
	// ****************************************
	// general registers: execution wins over a same-cycle bus write
	always_ff @(posedge pclk) begin
		if (commit && (op_q == exec_pkg::OP_XOR_RR ||
			op_q == exec_pkg::OP_MID_EXTRACT)) begin
			regs_q[rn] <= alu; // [RL15] [RL17]
		end else if (commit && op_q == exec_pkg::OP_XOR_IMM) begin
			regs_q[0] <= alu; // [RL15]
		end else if (apb_wr && paddr == exec_pkg::RDAT_OFS) begin
			regs_q[ridx_q] <= pwdata;
		end
	end

	// program counter, status and trap context
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= 32'h0000_0000;
			sr_q <= exec_pkg::SR_RST;
			tra_q <= 32'h0000_0000;
			spc_q <= 32'h0000_0000;
			ssr_q <= 32'h0000_0000;
			sgr_q <= 32'h0000_0000;
			evt_q <= 12'h000;
		end else if (trap_c) begin
			tra_q <= {22'h00_0000, imm, 2'b00}; // [RL8]
			spc_q <= pc_q + exec_pkg::PC_STEP; // [RL7]
			ssr_q <= sr_q; // [RL7]
			sgr_q <= regs_q[15]; // [RL7]
			sr_q[exec_pkg::SR_MD] <= 1'b1; // [RL9]
			sr_q[exec_pkg::SR_BL] <= 1'b1; // [RL9]
			sr_q[exec_pkg::SR_RB] <= 1'b1; // [RL9]
			evt_q <= exec_pkg::TRAP_EVT; // [RL10]
			pc_q <= vbr_q + exec_pkg::TRAP_OFS; // [RL11]
		end else if (commit) begin
			sr_q[exec_pkg::SR_T] <= t_new; // [RL1] [RL12] [RL13] [RL14]
			pc_q <= pc_q + exec_pkg::PC_STEP; // [RL18]
		end else if (apb_wr && state_q == exec_pkg::ST_IDLE) begin
			if (paddr == exec_pkg::PC_OFS) begin
				pc_q <= pwdata;
			end
			if (paddr == exec_pkg::STAT_OFS) begin
				sr_q <= pwdata;
			end
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	// plain software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			vbr_q <= 32'h0000_0000;
			gbr_q <= 32'h0000_0000;
			ridx_q <= 4'h0;
			imask_q <= '0;
		end else if (apb_wr) begin
			unique case (paddr)
				exec_pkg::CTRL_OFS: run_q <= pwdata[0];
				exec_pkg::VBR_OFS: vbr_q <= pwdata;
				exec_pkg::GBR_OFS: gbr_q <= pwdata;
				exec_pkg::RIDX_OFS: ridx_q <= pwdata[3:0];
				exec_pkg::IMASK_OFS: imask_q <= pwdata[exec_pkg::EV_W-1:0];
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		unique case (paddr)
			exec_pkg::CTRL_OFS: rdata_d = {31'h0000_0000, run_q};
			exec_pkg::STAT_OFS: rdata_d = sr_q;
			exec_pkg::PC_OFS: rdata_d = pc_q;
			exec_pkg::VBR_OFS: rdata_d = vbr_q;
			exec_pkg::GBR_OFS: rdata_d = gbr_q;
			exec_pkg::ISTAT_OFS: rdata_d = {29'h0000_0000, istat_q};
			exec_pkg::IMASK_OFS: rdata_d = {29'h0000_0000, imask_q};
			exec_pkg::TRA_OFS: rdata_d = tra_q;
			exec_pkg::EVT_OFS: rdata_d = {20'h0_0000, evt_q};
			exec_pkg::SPC_OFS: rdata_d = spc_q;
			exec_pkg::SSR_OFS: rdata_d = ssr_q;
			exec_pkg::SGR_OFS: rdata_d = sgr_q;
			exec_pkg::RIDX_OFS: rdata_d = {28'h000_0000, ridx_q};
			exec_pkg::RDAT_OFS: rdata_d = regs_q[ridx_q];
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// one wait-free access phase; ready is armed in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_rd;
			prdata <= apb_rd ? rdata_d : prdata;
			pslverr <= apb_rd && (paddr > exec_pkg::RDAT_OFS || paddr[1:0] != 2'b00);
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	assign ev_set = {bad_op, fault, trap_c};

	// sticky, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= '0;
			irq <= 1'b0;
		end else begin
			if (apb_wr && paddr == exec_pkg::ISTAT_OFS) begin
				istat_q <= (istat_q & ~pwdata[exec_pkg::EV_W-1:0]) | ev_set;
			end else begin
				istat_q <= istat_q | ev_set;
			end
			irq <= |(istat_q & imask_q);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	tas_flag_a: assert property ( // [RL1]
		commit && op_q == exec_pkg::OP_TEST_SET |-> cnt_q >= 3'h4 ##1
		sr_q[exec_pkg::SR_T] == ($past(rbyte_q) == 8'h00))
		else $error("test-and-set flag or length wrong");
	tas_msb_a: assert property ( // [RL2]
		mem_req && mem_we && mem_lock |-> mem_wdata[7])
		else $error("test-and-set write lacks bit 7");
	lock_span_a: assert property ( // [RL3]
		$fell(mem_lock) |-> $past(mem_we) && $past(mem_ack) || $past(fault))
		else $error("bus lock dropped before write");
	purge_dirty_a: assert property ( // [RL4]
		state_q == exec_pkg::ST_LOOK && cache_ack && cache_hit && cache_dirty &&
		!cache_ncache |=> state_q == exec_pkg::ST_WBACK && cache_op == exec_pkg::COP_WBACK)
		else $error("dirty hit not written back");
	purge_skip_a: assert property ( // [RL5]
		state_q == exec_pkg::ST_LOOK && cache_ack && (!cache_hit || cache_ncache)
		|=> state_q == exec_pkg::ST_READ && !cache_req && mem_req)
		else $error("miss still purged");
	store_chk_a: assert property ( // [RL6]
		mem_req && op_q == exec_pkg::OP_TEST_SET |-> mem_store_chk)
		else $error("test-and-set access not checked as store");
	trap_save_a: assert property ( // [RL7]
		trap_c |-> cnt_q == 3'h6 ##1 spc_q == $past(pc_q) + exec_pkg::PC_STEP)
		else $error("trap context wrong");
	trap_code_a: assert property ( // [RL8]
		trap_c |=> tra_q[9:2] == $past(imm) && tra_q[1:0] == 2'b00)
		else $error("trap code misplaced");
	trap_mode_a: assert property ( // [RL9]
		trap_c |=> sr_q[exec_pkg::SR_MD] && sr_q[exec_pkg::SR_BL] && sr_q[exec_pkg::SR_RB])
		else $error("trap mode flags not set");
	trap_evt_a: assert property ( // [RL10]
		trap_c |=> evt_q == exec_pkg::TRAP_EVT)
		else $error("trap event code wrong");
	trap_vec_a: assert property ( // [RL11]
		trap_c |=> pc_q == $past(vbr_q) + exec_pkg::TRAP_OFS)
		else $error("trap vector wrong");
	one_state_a: assert property ( // [RL12]
		taken && op_d == exec_pkg::OP_AND_RR |=> commit)
		else $error("register and-test not one state");
	pc_step_a: assert property ( // [RL18]
		commit && !trap_c |=> pc_q == $past(pc_q) + exec_pkg::PC_STEP)
		else $error("pc not advanced by two");

	tas_c: cover property (commit && op_q == exec_pkg::OP_TEST_SET);
	trap_c_c: cover property (trap_c);
	xorb_c: cover property (commit && op_q == exec_pkg::OP_XOR_MEM);
	fault_c: cover property (fault);
endmodule : logic_exec

// >>> rtl/exec_pkg.sv
package exec_pkg;
	// ****************************************
	// register map, byte addresses on apb
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] PC_OFS = 8'h08;
	localparam logic [7:0] VBR_OFS = 8'h0c;
	localparam logic [7:0] GBR_OFS = 8'h10;
	localparam logic [7:0] ISTAT_OFS = 8'h14;
	localparam logic [7:0] IMASK_OFS = 8'h18;
	localparam logic [7:0] TRA_OFS = 8'h1c;
	localparam logic [7:0] EVT_OFS = 8'h20;
	localparam logic [7:0] SPC_OFS = 8'h24;
	localparam logic [7:0] SSR_OFS = 8'h28;
	localparam logic [7:0] SGR_OFS = 8'h2c;
	localparam logic [7:0] RIDX_OFS = 8'h30;
	localparam logic [7:0] RDAT_OFS = 8'h34;
	// ****************************************
	// field positions and fixed values
	// ****************************************
	localparam int SR_T = 0;
	localparam int SR_BL = 28;
	localparam int SR_RB = 29;
	localparam int SR_MD = 30;
	localparam logic [31:0] SR_RST = 32'h0000_0000;
	localparam int EV_TRAP = 0;
	localparam int EV_FAULT = 1;
	localparam int EV_BADOP = 2;
	localparam int EV_W = 3;
	localparam logic [11:0] TRAP_EVT = 12'h160;
	localparam logic [31:0] TRAP_OFS = 32'h0000_0100;
	localparam logic [31:0] PC_STEP = 32'h0000_0002;
	localparam logic [7:0] MSB_SET = 8'h80;
	// ****************************************
	// least execution states per operation
	// ****************************************
	localparam logic [2:0] N_ONE = 3'h1;
	localparam logic [2:0] N_TSTB = 3'h3;
	localparam logic [2:0] N_XORB = 3'h4;
	localparam logic [2:0] N_TAS = 3'h5;
	localparam logic [2:0] N_TRAP = 3'h7;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_TEST_SET = 4'h1, OP_SOFT_TRAP = 4'h2,
		OP_AND_RR = 4'h3, OP_AND_IMM = 4'h4, OP_AND_MEM = 4'h5,
		OP_XOR_RR = 4'h6, OP_XOR_IMM = 4'h7, OP_XOR_MEM = 4'h8,
		OP_MID_EXTRACT = 4'h9
	} op_t;
	typedef enum logic [1:0] {
		COP_NONE = 2'h0, COP_LOOKUP = 2'h1, COP_WBACK = 2'h2, COP_INVAL = 2'h3
	} cache_op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_LOOK = 3'h1, ST_WBACK = 3'h2, ST_INVAL = 3'h3,
		ST_READ = 3'h4, ST_WRITE = 3'h5, ST_FINISH = 3'h6
	} st_t;
endpackage : exec_pkg

// >>> rtl/op_decode.sv
`timescale 1ns/10ps
// opcode classifier, purely combinational
module op_decode (
	input wire logic [15:0] instr,
	output exec_pkg::op_t op
);
	// match on fixed opcode fields only
	always_comb begin
		op = exec_pkg::OP_NONE;
		if (instr[15:12] == 4'h4 && instr[7:0] == 8'h1b) begin
			op = exec_pkg::OP_TEST_SET;
		end else if (instr[15:12] == 4'h2) begin
			unique case (instr[3:0])
				4'h8: op = exec_pkg::OP_AND_RR;
				4'ha: op = exec_pkg::OP_XOR_RR;
				4'hd: op = exec_pkg::OP_MID_EXTRACT;
				default: op = exec_pkg::OP_NONE;
			endcase
		end else begin
			unique case (instr[15:8])
				8'hc3: op = exec_pkg::OP_SOFT_TRAP;
				8'hc8: op = exec_pkg::OP_AND_IMM;
				8'hcc: op = exec_pkg::OP_AND_MEM;
				8'hca: op = exec_pkg::OP_XOR_IMM;
				8'hce: op = exec_pkg::OP_XOR_MEM;
				default: op = exec_pkg::OP_NONE;
			endcase
		end
	end
endmodule : op_decode

// >>> sim/far_side.sv
`timescale 1ns/10ps
// ****************************************
// data cache and byte memory bus model
// ****************************************
module far_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cache_req,
	input wire exec_pkg::cache_op_t cache_op,
	output logic cache_ack,
	output logic cache_hit,
	output logic cache_dirty,
	output logic cache_ncache,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_lock,
	input wire logic mem_store_chk,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic mem_fault,
	output logic [7:0] mem_rdata,
	input wire logic [3:0] cfg,
	input wire logic [1:0] lat,
	input wire logic ld,
	input wire logic [7:0] ld_a,
	input wire logic [7:0] ld_d
);
	logic [7:0] mem [256];
	logic [7:0] cnt [5];
	logic [1:0] wait_q;
	logic busy, go;
	// lookup results mean nothing outside the ack, so they lie there
	assign cache_hit = cache_ack ? cfg[0] : !cfg[0];
	assign cache_dirty = cache_ack ? cfg[1] : !cfg[1];
	assign cache_ncache = cache_ack ? cfg[2] : !cfg[2];
	assign busy = (cache_req || mem_req) && !cache_ack && !mem_ack;
	assign go = busy && wait_q == lat;
	// one answer per request after lat idle cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 2'h0;
			cache_ack <= 1'b0;
			mem_ack <= 1'b0;
			mem_fault <= 1'b0;
			mem_rdata <= 8'h00;
		end else begin
			cache_ack <= go && cache_req;
			mem_ack <= go && !cache_req;
			mem_fault <= go && !cache_req && cfg[3];
			mem_rdata <= go ? mem[mem_addr[7:0]] : ~mem_rdata; // stale data toggles
			wait_q <= (busy && !go) ? wait_q + 2'h1 : 2'h0;
		end
	end
	// byte store and tallies, taken at the edge the device sees the ack
	always_ff @(posedge pclk) begin
		if (ld)
			mem[ld_a] <= ld_d;
		else if (mem_req && mem_ack && mem_we && !mem_fault)
			mem[mem_addr[7:0]] <= mem_wdata;
		if (ld) begin
			for (int k = 0; k < 5; k++) cnt[k] <= 8'h00;
		end else begin
			if (cache_ack && cache_op == exec_pkg::COP_WBACK) cnt[0] <= cnt[0] + 8'h01;
			if (cache_ack && cache_op == exec_pkg::COP_INVAL) cnt[1] <= cnt[1] + 8'h01;
			if (mem_req && mem_ack && !mem_we) cnt[2] <= cnt[2] + 8'h01;
			if (mem_req && mem_ack && mem_we) cnt[3] <= cnt[3] + 8'h01;
			if (mem_req && mem_ack && mem_lock && mem_store_chk) cnt[4] <= cnt[4] + 8'h01;
		end
	end
endmodule : far_side

// >>> sim/logic_test_trap_instr_exec_bench.sv
`timescale 1ns/10ps
module logic_test_trap_instr_exec_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ld, err;
	logic instr_valid, instr_ready, mem_req, mem_we, mem_lock, mem_store_chk, mem_ack;
	logic mem_fault, cache_req, cache_ack, cache_hit, cache_dirty, cache_ncache;
	logic [7:0] paddr, mem_wdata, mem_rdata, ld_a, ld_d;
	logic [31:0] pwdata, prdata, rv, pc_e, mem_addr;
	logic [15:0] instr;
	logic [3:0] cfg;
	logic [1:0] lat;
	exec_pkg::cache_op_t cache_op;
	int fail_count, samples_checked;

	logic_exec logic_exec_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .instr_valid, .instr, .instr_ready, .mem_req, .mem_we,
		.mem_lock, .mem_store_chk, .mem_addr, .mem_wdata, .mem_ack, .mem_fault, .mem_rdata,
		.cache_req, .cache_op, .cache_ack, .cache_hit, .cache_dirty, .cache_ncache);
	far_side far_side_inst (.pclk, .presetn, .cache_req, .cache_op, .cache_ack, .cache_hit,
		.cache_dirty, .cache_ncache, .mem_req, .mem_we, .mem_lock, .mem_store_chk, .mem_addr,
		.mem_wdata, .mem_ack, .mem_fault, .mem_rdata, .cfg, .lat, .ld, .ld_a, .ld_d);

	// 50 MHz core clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, then an idle edge so psel never flips twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(pready, 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rv, e);
	endtask : rdchk
	task automatic setr(input logic [31:0] i, input logic [31:0] v);
		wr(exec_pkg::RIDX_OFS, i);
		wr(exec_pkg::RDAT_OFS, v);
	endtask : setr
	task automatic rgchk(input logic [31:0] i, input logic [31:0] e);
		wr(exec_pkg::RIDX_OFS, i);
		rdchk(exec_pkg::RDAT_OFS, e);
	endtask : rgchk
	// preload a byte and zero the far side tallies
	task automatic poke(input logic [7:0] a, input logic [7:0] d);
		ld <= 1'b1;
		ld_a <= a;
		ld_d <= d;
		@(posedge pclk);
		ld <= 1'b0;
		@(posedge pclk);
	endtask : poke
	// issue one word, time it to the return of ready, then check the pc
	task automatic op(input logic [15:0] code, input int least, input logic adv);
		int n;
		n = 0;
		instr_valid <= 1'b1;
		instr <= code;
		do begin
			@(posedge pclk);
			n++;
		end while (instr_ready !== 1'b1 && n < 300);
		instr_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (instr_ready !== 1'b1 && n < 300);
		chk(n > least && n < 300, 1'b1);
		if (adv)
			pc_e = pc_e + 32'h0000_0002;
		rdchk(exec_pkg::PC_OFS, pc_e);
	endtask : op
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		setr(1, 32'h0000_000f);
		setr(2, 32'h0000_00f0);
		op(16'h2128, 1, 1'b1);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0001);
		rgchk(2, 32'h0000_00f0);
		setr(2, 32'h0000_0018);
		op(16'h2128, 1, 1'b1);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0000);
		setr(0, 32'hffff_ff7f);
		op(16'hc880, 1, 1'b1);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0001);
		op(16'hcaf0, 1, 1'b1);
		rgchk(0, 32'hffff_ff8f);
		setr(0, 32'haaaa_aaaa);
		setr(1, 32'h5555_5555);
		op(16'h210a, 1, 1'b1);
		rgchk(1, 32'hffff_ffff);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0001);
		setr(0, 32'h0123_4567);
		setr(1, 32'h89ab_cdef);
		op(16'h210d, 1, 1'b1);
		rgchk(1, 32'h4567_89ab);
		$display("test regs done");
	endtask : t_regs
	task automatic t_mem();
		wr(8'h10, 32'h0000_0010); // global base
		setr(0, 32'h0000_0020);
		poke(8'h30, 8'ha5);
		op(16'hcca5, 3, 1'b1);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0000);
		op(16'hcc5a, 3, 1'b1);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0001);
		chk(far_side_inst.cnt[3], 8'h00);
		rgchk(0, 32'h0000_0020);
		lat <= 2'h2;
		op(16'hcea5, 4, 1'b1);
		chk(far_side_inst.mem[8'h30], 8'h00);
		chk(far_side_inst.cnt[3], 8'h01);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0001);
		$display("test mem done");
	endtask : t_mem
	// miss, clean hit, dirty hit, uncached dirty hit; latency grows each pass
	task automatic t_tas();
		logic [3:0] cases [4];
		logic [7:0] d;
		cases = '{4'b0000, 4'b0001, 4'b0011, 4'b0111};
		setr(3, 32'h0000_0040);
		for (int k = 0; k < 4; k++) begin
			d = k[0] ? 8'h05 : 8'h00;
			cfg <= cases[k];
			lat <= k[1:0];
			poke(8'h40, d);
			op(16'h431b, 5, 1'b1);
			rdchk(exec_pkg::STAT_OFS, {31'h0, !k[0]});
			chk(far_side_inst.mem[8'h40], d | 8'h80);
			chk(far_side_inst.cnt[0], k == 2);
			chk(far_side_inst.cnt[1], k == 1 || k == 2);
			chk(far_side_inst.cnt[4], 8'h02);
			chk(far_side_inst.cnt[2] + far_side_inst.cnt[3], 8'h02);
		end
		$display("test tas done");
	endtask : t_tas
	// faulted access: no store, no pc step, sticky event bit
	task automatic t_fault();
		cfg <= 4'b1000;
		poke(8'h40, 8'h00);
		op(16'h431b, 1, 1'b0);
		chk(far_side_inst.cnt[3], 8'h00);
		chk(far_side_inst.mem[8'h40], 8'h00);
		rdchk(exec_pkg::ISTAT_OFS, 32'h0000_0002);
		// unknown word is swallowed: event bit only, pc stays
		op(16'h0009, 1, 1'b0);
		rdchk(exec_pkg::ISTAT_OFS, 32'h0000_0006);
		wr(exec_pkg::ISTAT_OFS, 32'h0000_0006);
		rdchk(exec_pkg::ISTAT_OFS, 32'h0000_0000);
		cfg <= 4'b0000;
		$display("test fault done");
	endtask : t_fault
	task automatic t_trap();
		logic [31:0] spc_e;
		op(16'hc880, 1, 1'b1);
		setr(15, 32'h5555_0000);
		wr(8'h0c, 32'h0000_1000); // vector base
		wr(exec_pkg::IMASK_OFS, 32'h0000_0000);
		spc_e = pc_e + 32'h0000_0002;
		pc_e = 32'h0000_1100;
		op(16'hc32a, 7, 1'b0);
		rdchk(8'h1c, 32'h0000_00a8);
		rdchk(8'h24, spc_e);
		rdchk(8'h28, 32'h0000_0001);
		rdchk(8'h2c, 32'h5555_0000);
		rdchk(exec_pkg::STAT_OFS, 32'h7000_0001);
		rdchk(exec_pkg::EVT_OFS, 32'h0000_0160);
		chk(irq, 1'b0);
		wr(exec_pkg::IMASK_OFS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		wr(exec_pkg::ISTAT_OFS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		$display("test trap done");
	endtask : t_trap
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, instr_valid, ld, paddr, ld_a, ld_d} = '0;
		{pwdata, instr, cfg, lat, fail_count, samples_checked} = '0;
		pc_e = 32'h0000_0100;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(exec_pkg::STAT_OFS, 32'h0000_0000);
		apb(1'b0, 8'h38, 32'h0000_0000);
		chk(err, 1'b1);
		wr(exec_pkg::PC_OFS, pc_e);
		wr(exec_pkg::CTRL_OFS, 32'h0000_0001);
		t_regs();
		t_mem();
		t_tas();
		t_fault();
		t_trap();
		// reset in mid-run: core parked, pc back to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(exec_pkg::PC_OFS, 32'h0000_0000);
		chk(instr_ready, 1'b0);
		chk(irq, 1'b0);
		summarize();
	end
	// hang guard, well past the expected few hundred cycles
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
endmodule : logic_test_trap_instr_exec_bench
